// >>> hw/bdm_pkg.sv
// Debug support constants
package bdm_pkg;
   // Word width and field positions
   localparam int WORD_W = 16;
   localparam int OP_LSB = 12;
   localparam int OP_W = 4;
   localparam int SIZE_LSB = 10;
   localparam int SEL_LSB = 0;
   localparam int SEL_W = 4;

   // Command opcodes
   localparam logic [3:0] OP_NULL = 4'h0;
   localparam logic [3:0] OP_RD_DATA = 4'h1;
   localparam logic [3:0] OP_RD_ADDR = 4'h2;
   localparam logic [3:0] OP_WR_DATA = 4'h3;
   localparam logic [3:0] OP_WR_ADDR = 4'h4;
   localparam logic [3:0] OP_RD_SYS = 4'h5;
   localparam logic [3:0] OP_WR_SYS = 4'h6;
   localparam logic [3:0] OP_MEM_RD = 4'h7;
   localparam logic [3:0] OP_MEM_WR = 4'h8;
   localparam logic [3:0] OP_DUMP = 4'h9;
   localparam logic [3:0] OP_FILL = 4'hA;
   localparam logic [3:0] OP_RESUME = 4'hB;
   localparam logic [3:0] OP_PATCH = 4'hC;
   localparam logic [3:0] OP_PERIPH_RST = 4'hD;

   // Operand size codes
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;
   localparam logic [1:0] SZ_LONG = 2'h2;

   // Breakpoint exception vector number
   localparam logic [7:0] BKPT_VECTOR = 8'h0C;

   // Peripheral reset length
   localparam int PERIPH_RST_CYC = 512;

   // Reset values
   localparam logic [15:0] OUT_WORD_RST = 16'h0000;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;

   // Command interpreter states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR_HI,
      ST_ADDR_LO,
      ST_DATA_HI,
      ST_DATA_LO,
      ST_BUSY
   } bdm_state_t;
endpackage

// >>> hw/bdm_shift.sv
`timescale 1ns/1ps
// Serial in/out shifter
module bdm_shift #(
   parameter int WORD_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial side
   input wire logic shift_stb,
   input wire logic ser_in,
   output logic ser_out,
   // Word side
   input wire logic load_en,
   input wire logic [WORD_W-1:0] load_word,
   output logic word_valid,
   output logic [WORD_W-1:0] rx_word
);
   localparam int CW = $clog2(WORD_W);

   logic [WORD_W-1:0] in_q;
   logic [WORD_W-1:0] out_q;
   logic [CW-1:0] cnt_q;

   // Width check
   initial begin
      if (WORD_W < 2) $error("bdm_shift: WORD_W must be at least 2");
   end

   // Input shifter and bit counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_q <= '0;
         cnt_q <= '0;
         word_valid <= 1'b0;
         rx_word <= '0;
      end else begin
         word_valid <= 1'b0;
         if (shift_stb) begin
            in_q <= {in_q[WORD_W-2:0], ser_in};
            if (cnt_q == CW'(WORD_W - 1)) begin
               cnt_q <= '0;
               word_valid <= 1'b1;
               rx_word <= {in_q[WORD_W-2:0], ser_in};
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end

   // Output shifter, a load overrides a shift
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= '0;
      end else if (load_en) begin
         out_q <= load_word;
      end else if (shift_stb) begin
         out_q <= {out_q[WORD_W-2:0], 1'b0};
      end
   end

   assign ser_out = out_q[WORD_W-1];
endmodule

// >>> hw/bdm_track.sv
`timescale 1ns/1ps
// Pipeline tracking outputs for a bus analyzer
module bdm_track (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pipeline events from the core
   input wire logic instr_start,
   input wire logic mid_advance,
   input wire logic load_cycle,
   input wire logic flush,
   // Tracking outputs
   output logic pipe_advance_flag,
   output logic pipe_load_marker
);
   // Registered tracking flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pipe_advance_flag <= 1'b0;
         pipe_load_marker <= 1'b0;
      end else begin
         // [R1] advance on start or mid-advance
         pipe_advance_flag <= instr_start | mid_advance;
         // [R2] marks pipe load cycles
         // [R3] flushes also marked
         pipe_load_marker <= load_cycle | flush;
      end
   end
endmodule

// >>> hw/bdm_core.sv
`timescale 1ns/1ps
// Functional notes
// [R1] Advance flag pulses on instruction start and mid-advance.
// [R2] Load marker flags bus cycles loading the pipe.
// [R3] Load marker also flags pipeline flushes.
// [R4] Breakpoints from pin or internal hardware on any access.
// [R5] Hidden accesses raise no pin breakpoint without show cycles.
// [R6] Flushed prefetch hits dropped; operand hits always taken. The code ignores all hits while in background mode.
// [R7] Taken breakpoint gives vector 12 or background mode.
// [R8] Register read commands return the value serially.
// [R9] Register write commands load the operand.
// [R10] System register read returns the chosen register.
// [R11] System register write stores the operand.
// [R12] Memory read uses source space code.
// [R13] Memory write uses destination space code.
// [R14] Host opens a dump with a memory read.
// [R15] Host opens a fill with a memory write.
// [R16] Resume refills the pipe, continues at current PC.
// [R17] Patch stacks PC, then runs patch code.
// [R18] Peripheral reset drives reset pin 512 cycles.
// [R19] Null command changes nothing.
// [R20] Decode assembled word; wait for further words.
// [R21] Results shift out with the next word.
// [R22] Dump and fill step address before access.
// [R23] Commands act only in background mode.
module bdm_core (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   // Pipeline events from the core
   input wire logic INSTR_START,
   input wire logic MID_ADVANCE,
   input wire logic PIPE_LOAD_CYCLE,
   input wire logic PIPE_FLUSH,
   // Pipeline tracking outputs
   output logic PIPE_ADVANCE_FLAG,
   output logic PIPE_LOAD_MARKER,
   // Breakpoint sources
   input wire logic ACCESS_VALID,
   input wire logic ACCESS_PREFETCH,
   input wire logic ACCESS_INTERNAL,
   input wire logic SHOW_CYCLES,
   input wire logic BKPT_EXT,
   input wire logic BKPT_INT,
   input wire logic PREFETCH_EXEC,
   input wire logic BKPT_TO_BG,
   // Breakpoint results
   output logic EXC_REQ,
   output logic [7:0] EXC_VECTOR,
   output logic BG_MODE,
   // Serial debug port
   input wire logic DS_SHIFT,
   input wire logic DS_IN,
   output logic DS_OUT,
   // Core access
   output logic REQ_VALID,
   output logic [3:0] REQ_OP,
   output logic [1:0] REQ_SIZE,
   output logic [3:0] REQ_SEL,
   output logic [31:0] REQ_ADDR,
   output logic [31:0] REQ_WDATA,
   output logic [2:0] REQ_SPACE,
   input wire logic REQ_DONE,
   input wire logic [31:0] REQ_RDATA,
   // Space code registers of the core
   input wire logic [2:0] SRC_SPACE,
   input wire logic [2:0] DST_SPACE,
   // Peripheral reset pin, open drain
   output logic EXT_RESET_O,
   output logic EXT_RESET_OE
);
   localparam int W = bdm_pkg::WORD_W;
   localparam int RC_W = $clog2(bdm_pkg::PERIPH_RST_CYC + 1);

   bdm_pkg::bdm_state_t state_q;
   logic [3:0] op_q, sel_q, cmd_op;
   logic [1:0] size_q, cmd_size;
   logic [31:0] addr_q, wdata_q;
   logic [2:0] space_q;
   logic [W-1:0] res_lo_q, rx_word, load_word;
   logic [RC_W-1:0] rst_cnt_q;
   logic res_lo_pend_q, pf_pend_q, bkpt_ack, op_ack, ext_seen;
   logic word_valid, load_en, resume_done, leave_bg;

   // Item size in bytes
   function automatic logic [31:0] size_step(input logic [1:0] sz);
      unique case (sz)
         bdm_pkg::SZ_BYTE: size_step = 32'h0000_0001;
         bdm_pkg::SZ_WORD: size_step = 32'h0000_0002;
         default: size_step = 32'h0000_0004;
      endcase
   endfunction

   // Long operands need two serial words
   function automatic logic is_long(input logic [1:0] sz);
      is_long = (sz != bdm_pkg::SZ_BYTE) && (sz != bdm_pkg::SZ_WORD);
   endfunction

   // Ops returning a value to the host
   function automatic logic has_result(input logic [3:0] op);
      has_result = (op == bdm_pkg::OP_RD_DATA) || (op == bdm_pkg::OP_RD_ADDR) ||
                   (op == bdm_pkg::OP_RD_SYS) || (op == bdm_pkg::OP_MEM_RD) ||
                   (op == bdm_pkg::OP_DUMP);
   endfunction

   // Elaboration checks
   initial begin
      if (W != 16) $error("bdm_core: serial word must be 16 bits");
   end

   // Pipeline tracking, resume also flushes
   bdm_track u_track (
      .clk(CLK_SYS),
      .rst_n(RESET_N),
      .instr_start(INSTR_START),
      .mid_advance(MID_ADVANCE),
      .load_cycle(PIPE_LOAD_CYCLE),
      .flush(PIPE_FLUSH | resume_done),
      .pipe_advance_flag(PIPE_ADVANCE_FLAG),
      .pipe_load_marker(PIPE_LOAD_MARKER)
   );

   // Serial shifter
   bdm_shift #(
      .WORD_W(W)
   ) u_shift (
      .clk(CLK_SYS),
      .rst_n(RESET_N),
      .shift_stb(DS_SHIFT),
      .ser_in(DS_IN),
      .ser_out(DS_OUT),
      .load_en(load_en),
      .load_word(load_word),
      .word_valid(word_valid),
      .rx_word(rx_word)
   );

   // Command fields of an assembled word
   assign cmd_op = rx_word[bdm_pkg::OP_LSB +: bdm_pkg::OP_W];
   assign cmd_size = rx_word[bdm_pkg::SIZE_LSB +: 2];

   // [R5] external hits need visible accesses
   assign ext_seen = BKPT_EXT & (~ACCESS_INTERNAL | SHOW_CYCLES);

   // [R6] operand hits acknowledged at once
   assign op_ack = ACCESS_VALID & ~ACCESS_PREFETCH & (ext_seen | BKPT_INT);

   // [R6] prefetch hits wait for execution
   assign bkpt_ack = ~BG_MODE & (op_ack | (pf_pend_q & PREFETCH_EXEC & ~PIPE_FLUSH));

   // Prefetch breakpoint tag, dropped on flush
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         pf_pend_q <= 1'b0;
      end else begin
         // [R4] any access may raise a request
         if (ACCESS_VALID && ACCESS_PREFETCH && (ext_seen || BKPT_INT)) begin
            pf_pend_q <= 1'b1;
         end else if (PIPE_FLUSH || PREFETCH_EXEC || BG_MODE) begin
            // [R6] flushed prefetch tag ignored
            pf_pend_q <= 1'b0;
         end
      end
   end

   // Exception request output
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         EXC_REQ <= 1'b0;
         EXC_VECTOR <= 8'h00;
      end else begin
         // [R7] vector 12 unless background
         EXC_REQ <= bkpt_ack & ~BKPT_TO_BG;
         EXC_VECTOR <= bdm_pkg::BKPT_VECTOR;
      end
   end

   // [R16] [R17] completion leaves background
   assign resume_done = (state_q == bdm_pkg::ST_BUSY) && REQ_DONE &&
                        (op_q == bdm_pkg::OP_RESUME);
   assign leave_bg = (state_q == bdm_pkg::ST_BUSY) && REQ_DONE &&
                     ((op_q == bdm_pkg::OP_RESUME) || (op_q == bdm_pkg::OP_PATCH));

   // Background mode flag
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         BG_MODE <= 1'b0;
      end else if (bkpt_ack && BKPT_TO_BG) begin
         // [R7] enter background instead
         BG_MODE <= 1'b1;
      end else if (leave_bg) begin
         BG_MODE <= 1'b0;
      end
   end

   // Command interpreter
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         state_q <= bdm_pkg::ST_IDLE;
         op_q <= bdm_pkg::OP_NULL;
         size_q <= bdm_pkg::SZ_BYTE;
         sel_q <= 4'h0;
         addr_q <= bdm_pkg::ADDR_RST;
         wdata_q <= 32'h0000_0000;
         space_q <= 3'h0;
      end else begin
         unique case (state_q)
            bdm_pkg::ST_IDLE: begin
               // [R23] ignored outside background
               if (word_valid && BG_MODE) begin
                  // [R20] decode assembled command
                  op_q <= cmd_op;
                  size_q <= cmd_size;
                  sel_q <= rx_word[bdm_pkg::SEL_LSB +: bdm_pkg::SEL_W];
                  unique case (cmd_op)
                     // [R8] [R16] [R17] read register, resume and patch
                     bdm_pkg::OP_RD_DATA, bdm_pkg::OP_RD_ADDR,
                     bdm_pkg::OP_RD_SYS, bdm_pkg::OP_RESUME,
                     bdm_pkg::OP_PATCH: begin
                        state_q <= bdm_pkg::ST_BUSY;
                     end
                     // [R9] [R11] register write operands
                     bdm_pkg::OP_WR_DATA, bdm_pkg::OP_WR_ADDR,
                     bdm_pkg::OP_WR_SYS: begin
                        size_q <= bdm_pkg::SZ_LONG;
                        state_q <= bdm_pkg::ST_DATA_HI;
                     end
                     // [R12] read space code
                     bdm_pkg::OP_MEM_RD: begin
                        space_q <= SRC_SPACE;
                        state_q <= bdm_pkg::ST_ADDR_HI;
                     end
                     // [R13] write space code
                     bdm_pkg::OP_MEM_WR: begin
                        space_q <= DST_SPACE;
                        state_q <= bdm_pkg::ST_ADDR_HI;
                     end
                     // [R22] dump advances address
                     bdm_pkg::OP_DUMP: begin
                        addr_q <= addr_q + size_step(cmd_size);
                        space_q <= SRC_SPACE;
                        state_q <= bdm_pkg::ST_BUSY;
                     end
                     // [R22] fill advances address
                     bdm_pkg::OP_FILL: begin
                        addr_q <= addr_q + size_step(cmd_size);
                        space_q <= DST_SPACE;
                        state_q <= is_long(cmd_size) ? bdm_pkg::ST_DATA_HI
                                                     : bdm_pkg::ST_DATA_LO;
                     end
                     // [R19] null and reset stay idle
                     default: begin
                        state_q <= bdm_pkg::ST_IDLE;
                     end
                  endcase
               end
            end
            bdm_pkg::ST_ADDR_HI: begin
               // [R20] wait for address words
               if (word_valid) begin
                  addr_q[31:16] <= rx_word;
                  state_q <= bdm_pkg::ST_ADDR_LO;
               end
            end
            bdm_pkg::ST_ADDR_LO: begin
               if (word_valid) begin
                  addr_q[15:0] <= rx_word;
                  if (op_q == bdm_pkg::OP_MEM_WR) begin
                     state_q <= is_long(size_q) ? bdm_pkg::ST_DATA_HI
                                                : bdm_pkg::ST_DATA_LO;
                  end else begin
                     state_q <= bdm_pkg::ST_BUSY;
                  end
               end
            end
            bdm_pkg::ST_DATA_HI: begin
               // [R20] wait for operand words
               if (word_valid) begin
                  wdata_q[31:16] <= rx_word;
                  state_q <= bdm_pkg::ST_DATA_LO;
               end
            end
            bdm_pkg::ST_DATA_LO: begin
               if (word_valid) begin
                  wdata_q[15:0] <= rx_word;
                  if (!is_long(size_q)) begin
                     wdata_q[31:16] <= 16'h0000;
                  end
                  state_q <= bdm_pkg::ST_BUSY;
               end
            end
            bdm_pkg::ST_BUSY: begin
               if (REQ_DONE) begin
                  state_q <= bdm_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= bdm_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Core request
   assign REQ_VALID = (state_q == bdm_pkg::ST_BUSY);
   assign REQ_OP = op_q;
   assign REQ_SIZE = size_q;
   assign REQ_SEL = sel_q;
   assign REQ_ADDR = addr_q;
   assign REQ_WDATA = wdata_q;
   assign REQ_SPACE = space_q;

   // [R21] result into output shifter
   always_comb begin
      load_en = 1'b0;
      load_word = bdm_pkg::OUT_WORD_RST;
      if (REQ_VALID && REQ_DONE && has_result(op_q)) begin
         load_en = 1'b1;
         load_word = is_long(size_q) || (op_q != bdm_pkg::OP_MEM_RD &&
                     op_q != bdm_pkg::OP_DUMP) ? REQ_RDATA[31:16] : REQ_RDATA[15:0];
      end else if (word_valid && res_lo_pend_q) begin
         load_en = 1'b1;
         load_word = res_lo_q;
      end
   end

   // Low half of a long result
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         res_lo_q <= bdm_pkg::OUT_WORD_RST;
         res_lo_pend_q <= 1'b0;
      end else if (REQ_VALID && REQ_DONE && has_result(op_q)) begin
         // [R10] system and general results
         res_lo_q <= REQ_RDATA[15:0];
         res_lo_pend_q <= is_long(size_q) || (op_q != bdm_pkg::OP_MEM_RD &&
                          op_q != bdm_pkg::OP_DUMP);
      end else if (word_valid) begin
         res_lo_pend_q <= 1'b0;
      end
   end

   // Peripheral reset pulse counter
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_cnt_q <= '0;
      end else if (rst_cnt_q != '0) begin
         rst_cnt_q <= rst_cnt_q - 1'b1;
      end else if (state_q == bdm_pkg::ST_IDLE && word_valid && BG_MODE &&
                   cmd_op == bdm_pkg::OP_PERIPH_RST) begin
         // [R18] drive reset 512 cycles
         rst_cnt_q <= RC_W'(bdm_pkg::PERIPH_RST_CYC);
      end
   end

   // Reset pin driven low while counting
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         EXT_RESET_OE <= 1'b0;
      end else begin
         // [R18] core itself not reset
         EXT_RESET_OE <= (rst_cnt_q > RC_W'(1)) ||
                         (rst_cnt_q == '0 && state_q == bdm_pkg::ST_IDLE &&
                          word_valid && BG_MODE && cmd_op == bdm_pkg::OP_PERIPH_RST);
      end
   end

   // Open drain, only ever pulls low
   assign EXT_RESET_O = 1'b0;
endmodule

// >>> test/bdm_props.sv
`timescale 1ns/1ps
// Port checker
module bdm_props (
   // Clock and reset
   input wire logic CLK_SYS, RESET_N,
   // Pipeline tracking
   input wire logic INSTR_START, MID_ADVANCE, PIPE_LOAD_CYCLE, PIPE_FLUSH,
   input wire logic PIPE_ADVANCE_FLAG, PIPE_LOAD_MARKER,
   // Breakpoints
   input wire logic ACCESS_VALID, ACCESS_PREFETCH, ACCESS_INTERNAL, SHOW_CYCLES,
   input wire logic BKPT_EXT, BKPT_INT, PREFETCH_EXEC, BKPT_TO_BG, EXC_REQ, BG_MODE,
   input wire logic [7:0] EXC_VECTOR,
   // Core requests and reset pin
   input wire logic REQ_VALID, REQ_DONE, EXT_RESET_OE,
   input wire logic [3:0] REQ_OP,
   input wire logic [31:0] REQ_ADDR
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESET_N);

   logic [9:0] hi_cnt_q;

   // Reset pin drive length
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N)
         hi_cnt_q <= 10'h000;
      else
         hi_cnt_q <= EXT_RESET_OE ? hi_cnt_q + 10'h001 : 10'h000;
   end

   // Hits outside background
   sequence s_op_hit;
      ACCESS_VALID && !ACCESS_PREFETCH && BKPT_INT && !BG_MODE;
   endsequence
   sequence s_pf_hit;
      ACCESS_VALID && ACCESS_PREFETCH && BKPT_INT && !BG_MODE && !BKPT_TO_BG;
   endsequence

   property p_adv;
      INSTR_START || MID_ADVANCE |=> PIPE_ADVANCE_FLAG;
   endproperty
   a_adv: assert property (p_adv) else $error("advance flag missing");
   property p_adv_idle;
      !(INSTR_START || MID_ADVANCE) |=> !PIPE_ADVANCE_FLAG;
   endproperty
   a_adv_idle: assert property (p_adv_idle) else $error("stray advance flag");
   property p_load;
      PIPE_LOAD_CYCLE |=> PIPE_LOAD_MARKER;
   endproperty
   a_load: assert property (p_load) else $error("load marker missing");
   property p_flush;
      PIPE_FLUSH |=> PIPE_LOAD_MARKER;
   endproperty
   a_flush: assert property (p_flush) else $error("flush not marked");
   property p_exc;
      s_op_hit ##0 !BKPT_TO_BG |=> EXC_REQ && EXC_VECTOR == 8'h0C;
   endproperty
   a_exc: assert property (p_exc) else $error("operand hit not taken");
   property p_bg;
      s_op_hit ##0 BKPT_TO_BG |=> BG_MODE && !EXC_REQ;
   endproperty
   a_bg: assert property (p_bg) else $error("background not entered");
   property p_pf_drop;
      s_pf_hit ##2 (PIPE_FLUSH && !PREFETCH_EXEC) ##1 (PREFETCH_EXEC && !PIPE_FLUSH)
         |=> !EXC_REQ;
   endproperty
   a_pf_drop: assert property (p_pf_drop) else $error("flushed hit taken");
   property p_show;
      ACCESS_VALID && ACCESS_INTERNAL && !SHOW_CYCLES && BKPT_EXT && !BKPT_INT
         && !PREFETCH_EXEC |=> !EXC_REQ && !$rose(BG_MODE);
   endproperty
   a_show: assert property (p_show) else $error("hidden access hit taken");
   property p_prst;
      $fell(EXT_RESET_OE) |-> hi_cnt_q == 10'h200;
   endproperty
   a_prst: assert property (p_prst) else $error("reset pulse length wrong");
   property p_hold;
      REQ_VALID && !REQ_DONE |=> REQ_VALID && $stable(REQ_OP) && $stable(REQ_ADDR);
   endproperty
   a_hold: assert property (p_hold) else $error("request changed early");
endmodule

bind bdm_core bdm_props u_props (.*);

// >>> test/bdm_core_model.sv
`timescale 1ns/1ps
// Core stub answering requests
module bdm_core_model (
   // Clock and reset
   input wire logic clk, rst_n,
   // Answer speed
   input wire logic slow,
   // Request side
   input wire logic req_valid,
   input wire logic [3:0] req_sel,
   output logic req_done,
   output logic [31:0] req_rdata
);
   logic [3:0] wait_q;

   // Answer after a short or long wait; data churns when not valid
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q <= 4'h0;
         req_done <= 1'b0;
         req_rdata <= 32'h0000_0000;
      end else if (req_valid && !req_done && wait_q == (slow ? 4'h9 : 4'h1)) begin
         wait_q <= 4'h0;
         req_done <= 1'b1;
         req_rdata <= {28'hC0DE5A7, req_sel};
      end else begin
         wait_q <= (req_valid && !req_done) ? wait_q + 4'h1 : 4'h0;
         req_done <= 1'b0;
         req_rdata <= ~req_rdata;
      end
   end
endmodule

// >>> test/bdm_core_tb.sv
`timescale 1ns/1ps
// Directed bench
module bdm_core_tb;
   logic CLK_SYS = 1'b0, RESET_N = 1'b0, slow = 1'b0;
   logic INSTR_START = 1'b0, MID_ADVANCE = 1'b0, PIPE_LOAD_CYCLE = 1'b0, PIPE_FLUSH = 1'b0;
   logic ACCESS_VALID = 1'b0, ACCESS_PREFETCH = 1'b0, ACCESS_INTERNAL = 1'b0;
   logic SHOW_CYCLES = 1'b0, BKPT_EXT = 1'b0, BKPT_INT = 1'b0, PREFETCH_EXEC = 1'b0;
   logic BKPT_TO_BG = 1'b0, DS_SHIFT = 1'b0, DS_IN = 1'b0;
   logic PIPE_ADVANCE_FLAG, PIPE_LOAD_MARKER, EXC_REQ, BG_MODE, DS_OUT, REQ_VALID;
   logic REQ_DONE, EXT_RESET_O, EXT_RESET_OE;
   logic [7:0] EXC_VECTOR;
   logic [3:0] REQ_OP, REQ_SEL, c_op, c_sel;
   logic [1:0] REQ_SIZE, c_size;
   logic [2:0] REQ_SPACE, c_space;
   logic [2:0] SRC_SPACE = 3'h5, DST_SPACE = 3'h6;
   logic [31:0] REQ_ADDR, REQ_WDATA, REQ_RDATA, c_addr, c_wdata;
   logic [15:0] r, hi;
   int fail_count = 0, total_checks = 0, n_req = 0;

   bdm_core DUT (.*);
   bdm_core_model u_model (.clk(CLK_SYS), .rst_n(RESET_N), .slow(slow),
      .req_valid(REQ_VALID), .req_sel(REQ_SEL), .req_done(REQ_DONE), .req_rdata(REQ_RDATA));

   // 20 MHz clock
   always #25 CLK_SYS = ~CLK_SYS;

   // Log completed requests
   always @(posedge CLK_SYS) begin
      if (REQ_VALID === 1'b1 && REQ_DONE === 1'b1) begin
         {c_op, c_sel, c_size, c_space} = {REQ_OP, REQ_SEL, REQ_SIZE, REQ_SPACE};
         {c_addr, c_wdata} = {REQ_ADDR, REQ_WDATA};
         n_req++;
      end
   end

   // Verdict and end of run
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One serial word in, one word out, MSB first
   task automatic xfer(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         @(posedge CLK_SYS);
         if (i < 15)
            r[i + 1] = DS_OUT;
         DS_SHIFT <= 1'b1;
         DS_IN <= w[i];
      end
      @(posedge CLK_SYS);
      r[0] = DS_OUT;
      DS_SHIFT <= 1'b0;
   endtask

   task automatic wait_done;
      int n0 = n_req;
      repeat (40) begin
         @(posedge CLK_SYS);
         #1;
         if (n_req != n0)
            break;
      end
      check(n_req, n0 + 1);
   endtask

   // Access, flags {show, prefetch, internal, ext, int}
   task automatic acc(input logic [4:0] f);
      @(posedge CLK_SYS);
      SHOW_CYCLES <= f[4];
      {ACCESS_VALID, ACCESS_PREFETCH, ACCESS_INTERNAL, BKPT_EXT, BKPT_INT} <= {1'b1, f[3:0]};
      @(posedge CLK_SYS);
      {ACCESS_VALID, ACCESS_PREFETCH, ACCESS_INTERNAL, BKPT_EXT, BKPT_INT} <= 5'h00;
      #1;
   endtask

   task automatic pexec(input logic fl);
      @(posedge CLK_SYS);
      PIPE_FLUSH <= fl;
      @(posedge CLK_SYS);
      PIPE_FLUSH <= 1'b0;
      PREFETCH_EXEC <= 1'b1;
      @(posedge CLK_SYS);
      PREFETCH_EXEC <= 1'b0;
      #1;
   endtask

   task automatic t_track;
      @(posedge CLK_SYS);
      INSTR_START <= 1'b1;
      @(posedge CLK_SYS);
      {INSTR_START, MID_ADVANCE, PIPE_LOAD_CYCLE} <= 3'h3;
      #1 check(PIPE_ADVANCE_FLAG, 1'b1);
      @(posedge CLK_SYS);
      {MID_ADVANCE, PIPE_LOAD_CYCLE, PIPE_FLUSH} <= 3'h1;
      #1 check({PIPE_ADVANCE_FLAG, PIPE_LOAD_MARKER}, 2'h3);
      @(posedge CLK_SYS);
      PIPE_FLUSH <= 1'b0;
      #1 check({PIPE_ADVANCE_FLAG, PIPE_LOAD_MARKER}, 2'h1);
      @(posedge CLK_SYS);
      #1 check(PIPE_LOAD_MARKER, 1'b0);
      $display("tracking test done");
   endtask

   task automatic t_bkpt;
      acc(5'h01);
      check({EXC_REQ, EXC_VECTOR}, 9'h10C);
      acc(5'h06);
      check(EXC_REQ, 1'b0);
      acc(5'h16);
      check(EXC_REQ, 1'b1);
      acc(5'h09);
      check(EXC_REQ, 1'b0);
      pexec(1'b1);
      check(EXC_REQ, 1'b0);
      acc(5'h09);
      pexec(1'b0);
      check(EXC_REQ, 1'b1);
      $display("breakpoint test done");
   endtask

   // Word with no effect
   task automatic t_quiet(input logic [15:0] w);
      int n0 = n_req;
      xfer(w);
      repeat (6) @(posedge CLK_SYS);
      #1 check({n_req, EXT_RESET_OE}, {n0, 1'b0});
   endtask

   task automatic t_enter_bg;
      @(posedge CLK_SYS);
      BKPT_TO_BG <= 1'b1;
      acc(5'h01);
      check({BG_MODE, EXC_REQ}, 2'h2);
   endtask

   task automatic t_regs;
      logic [15:0] cmd [6];
      cmd = '{16'h3003, 16'h4007, 16'h600A, 16'h1003, 16'h2007, 16'h500A};
      for (int i = 0; i < 6; i++) begin
         slow <= i[0];
         xfer(cmd[i]);
         if (i < 3) begin
            xfer(cmd[i]);
            xfer(~cmd[i]);
         end
         wait_done;
         check({c_op, c_sel}, {cmd[i][15:12], cmd[i][3:0]});
         if (i < 3)
            check(c_wdata, {cmd[i], ~cmd[i]});
         else begin
            xfer(16'h0000);
            hi = r;
            xfer(16'h0000);
            check({hi, r}, {28'hC0DE5A7, cmd[i][3:0]});
         end
      end
      $display("register test done");
   endtask

   // Block fill and dump
   task automatic t_mem;
      xfer(16'h8800);
      xfer(16'h0001);
      xfer(16'h2000);
      xfer(16'hCAFE);
      xfer(16'hF00D);
      wait_done;
      check({c_op, c_space, c_addr, c_wdata[7:0]}, {4'h8, 3'h6, 32'h0001_2000, 8'h0D});
      xfer(16'hA800);
      xfer(16'h1111);
      xfer(16'h2222);
      wait_done;
      check({c_op, c_space, c_addr}, {4'hA, 3'h6, 32'h0001_2004});
      check(c_wdata, 32'h1111_2222);
      xfer(16'h7400);
      xfer(16'h0001);
      xfer(16'h3000);
      wait_done;
      check({c_op, c_size, c_space, c_addr}, {4'h7, 2'h1, 3'h5, 32'h0001_3000});
      xfer(16'h9400);
      check(r, 16'h5A70);
      wait_done;
      check({c_op, c_space, c_addr}, {4'h9, 3'h5, 32'h0001_3002});
      xfer(16'h0000);
      check(r, 16'h5A70);
      $display("memory test done");
   endtask

   task automatic t_prst;
      int n = 0;
      xfer(16'hD000);
      repeat (600) begin
         @(posedge CLK_SYS);
         if (EXT_RESET_OE === 1'b1)
            n++;
      end
      check({n, EXT_RESET_O, BG_MODE}, {32'd512, 2'h1});
      $display("peripheral reset test done");
   endtask

   task automatic t_go;
      logic m = 1'b0;
      xfer(16'hC000);
      wait_done;
      repeat (2) @(posedge CLK_SYS);
      #1 check({c_op, BG_MODE}, {4'hC, 1'b0});
      t_enter_bg;
      xfer(16'hB000);
      wait_done;
      repeat (3) begin
         @(posedge CLK_SYS);
         m = m | PIPE_LOAD_MARKER;
      end
      check({c_op, m, BG_MODE}, {4'hB, 2'h2});
      $display("resume test done");
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge CLK_SYS);
      RESET_N <= 1'b1;
      t_track;
      t_bkpt;
      t_quiet(16'hD000);
      t_quiet(16'h1003);
      t_enter_bg;
      t_quiet(16'h0000);
      t_regs;
      t_mem;
      t_prst;
      t_go;
      close_out;
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge CLK_SYS);
      fail_count++;
      close_out;
   end
endmodule
